// [bench/rx_b_bit_source.sv]
// bit-serial source standing in for the channel b deserializer
`timescale 1ns/1ps
`default_nettype none
module rx_b_bit_source (
  input wire logic clk,
  output rx_b_irq_pkg::rx_bit_t bit_o
);
  import rx_b_irq_pkg::*;
  initial bit_o = '0;
  // between strobes valid and data flip, so nothing leans on a stale bit
  task put(input logic v, input logic b);
    bit_o <= '{strobe: 1'b1, valid: v, data: b};
    @(posedge clk);
    bit_o <= '{strobe: 1'b0, valid: ~v, data: ~b};
    @(posedge clk);
  endtask
  // msb first, n bits of b
  task send(input logic [7:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) put(1'b1, b[i]);
    repeat (3) @(posedge clk);
  endtask
  task gap(input int n);
    repeat (n) put(1'b0, 1'b0);
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [bench/rx_b_irq_props.sv]
// port assertions for the channel b receive interrupt block
`timescale 1ns/1ps
`default_nettype none
module rx_b_irq_props #(
  parameter int LEN_W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire rx_b_irq_pkg::rx_bit_t RX_BIT,
  input wire logic IRQ
);
  import rx_b_irq_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  wire logic wr_en = PSEL && PENABLE && PREADY && PWRITE;
  wire logic rd_done = PREADY && !PWRITE;
  a_ready_first: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside a read");
  a_err_unmapped: assert property (PREADY && PADDR > 8'h14 |-> PSLVERR)
    else $error("unmapped access not refused");
  a_hold_count: assert property (rd_done && PADDR == 8'h04 |-> PRDATA[31:8] <= 24'h8)
    else $error("holding bit count above eight");
  a_enable_field: assert property (rd_done && PADDR == 8'h00 |-> PRDATA[3:0] == 4'h0)
    else $error("enable low nibble not zero");
  a_irq_unenabled: assert property (wr_en && PADDR == 8'h00 && PWDATA[7:4] == 4'h0 |-> ##2 !IRQ)
    else $error("irq with all enables off");
  a_irq_unmasked: assert property (wr_en && PADDR == 8'h14 && PWDATA[7:4] == 4'h0 |-> ##2 !IRQ)
    else $error("irq with all sources masked");
  a_irq_reset: assert property ($fell(RESET) |-> !IRQ)
    else $error("irq high after reset");
endmodule
bind rx_chan_b_irq_enable rx_b_irq_props #(.LEN_W(LEN_W)) props (.CLK_SYS(CLK_SYS),
  .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_BIT(RX_BIT),
  .IRQ(IRQ));
`default_nettype wire

// [bench/rx_chan_b_irq_enable_test.sv]
// self-checking bench for the channel b receive interrupt block
`timescale 1ns/1ps
`default_nettype none
module rx_chan_b_irq_enable_test;
  import rx_b_irq_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, irq, e;
  rx_bit_t rx_bit;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  rx_b_bit_source src (.clk(clk_sys), .bit_o(rx_bit));
  rx_chan_b_irq_enable dut (.CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_BIT(rx_bit), .IRQ(irq));
  initial forever #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one idle cycle after each transfer keeps psel from being driven twice at one edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, r);
  endtask
  task irq_is(input logic x);
    int n;
    n = 0;
    while (irq !== x && n < 8) begin
      @(posedge clk_sys);
      n++;
    end
    chk("irq", {31'h0, x}, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd("enable", 8'h00, 32'h0);
    rd("mask", 8'h14, 32'hf0);
    rd("eof_len", 8'h0c, 32'h0);
    rd("rx_stat", 8'h08, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    rd("hold_empty", 8'h04, 32'h0);
    rd("irq_stat", 8'h10, 32'h80);
    irq_is(1'b0);
    wr(8'h00, 32'h80);
    irq_is(1'b1);
    wr(8'h00, 32'h0);
    irq_is(1'b0);
    wr(8'h10, 32'h80);
    rd("irq_stat", 8'h10, 32'h0);
    wr(8'h00, 32'h10);
    src.send(8'ha5, 8);
    irq_is(1'b1);
    rd("rx_stat", 8'h08, 32'h801);
    rd("hold", 8'h04, 32'h8a5);
    rd("irq_stat", 8'h10, 32'h10);
    wr(8'h10, 32'hf0);
    irq_is(1'b0);
    src.send(8'h3c, 8);
    src.send(8'hc3, 8);
    rd("irq_stat", 8'h10, 32'h50);
    wr(8'h00, 32'h40);
    rd("hold", 8'h04, 32'h8c3);
    irq_is(1'b1);
    wr(8'h10, 32'hf0);
    irq_is(1'b0);
    src.gap(1);
    rd("irq_stat", 8'h10, 32'h30);
    rd("rx_stat", 8'h08, 32'h3);
    rd("irq_stat", 8'h10, 32'h10);
    rd("hold", 8'h04, 32'h0);
    wr(8'h10, 32'hf0);
    src.gap(2);
    rd("irq_stat", 8'h10, 32'h0);
    wr(8'h0c, 32'h2);
    rd("eof_len", 8'h0c, 32'h2);
    wr(8'h00, 32'h20);
    src.send(8'h05, 3);
    src.gap(2);
    rd("irq_stat", 8'h10, 32'h0);
    src.gap(1);
    rd("irq_stat", 8'h10, 32'h30);
    irq_is(1'b1);
    rd("rx_stat", 8'h08, 32'h303);
    irq_is(1'b0);
    rd("hold", 8'h04, 32'h305);
    wr(8'h10, 32'hf0);
    rd("hold_empty", 8'h04, 32'h0);
    wr(8'h00, 32'h80);
    wr(8'h14, 32'h70);
    irq_is(1'b0);
    wr(8'h14, 32'hf0);
    irq_is(1'b1);
    wr(8'h14, 32'h0);
    irq_is(1'b0);
    close_out;
  end
endmodule
`default_nettype wire

// [common/rx_b_irq_defines.svh]
// register offsets, field positions and reset values of the channel b receive block
`ifndef RX_B_IRQ_DEFINES_SVH
`define RX_B_IRQ_DEFINES_SVH

// apb byte offsets, one aligned word each
`define OFF_IRQ_ENABLE 8'h00
`define OFF_HOLD_B 8'h04
`define OFF_RX_STATUS 8'h08
`define OFF_EOF_LEN 8'h0c
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14

// event bit positions, shared by enable, status and mask
`define BIT_UNDERFLOW_B 7
`define BIT_OVERFLOW_B 6
`define BIT_EOF_B 5
`define BIT_FULL_B 4
`define EVENT_LO 4
`define EVENT_HI 7

// receive status fields
`define STAT_HOLD_FULL 0
`define STAT_EOF_PENDING 1
`define STAT_NBITS_LO 8
`define STAT_NBITS_HI 11

// holding register read fields
`define HOLD_DATA_HI 7
`define HOLD_NBITS_LO 8
`define HOLD_NBITS_HI 11

// reset values, and the bit count of a full byte
`define RST_IRQ_ENABLE 4'h0
`define RST_IRQ_MASK 4'hf
`define RST_EOF_LEN 8'h00
`define BITS_PER_BYTE 4'h8

`endif

// [common/rx_b_irq_pkg.sv]
// types shared by the channel b receive interrupt block
package rx_b_irq_pkg;

  // one bit from the channel b deserializer, same clock
  typedef struct packed {
    logic strobe;
    logic valid;
    logic data;
  } rx_bit_t;

  // a transfer into the holding register
  typedef struct packed {
    logic load;
    logic eof;
    logic [3:0] nbits;
    logic [7:0] data;
  } rx_xfer_t;

endpackage

// [core/rx_b_deframer.sv]
// channel b bit assembler with end-of-frame detection
`timescale 1ns/1ps
`default_nettype none
`include "rx_b_irq_defines.svh"

module rx_b_deframer #(
  parameter int LEN_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire rx_b_irq_pkg::rx_bit_t rx_bit,
  input wire logic [LEN_W-1:0] eof_len,
  output rx_b_irq_pkg::rx_xfer_t xfer
);
  import rx_b_irq_pkg::*;

  logic [7:0] shift_q;
  logic [3:0] nbits_q;
  logic seen_valid_q;
  logic [LEN_W:0] invalid_q;
  logic [LEN_W:0] invalid_next;
  logic [3:0] nbits_next;
  logic eof_hit;
  rx_xfer_t xfer_q;

  assign invalid_next = invalid_q + {{LEN_W{1'b0}}, 1'b1};
  assign nbits_next = nbits_q + 4'h1;
  // count exceeds length; length zero ends on the first invalid bit
  assign eof_hit = rx_bit.strobe & ~rx_bit.valid & seen_valid_q &
                   (invalid_next > {1'b0, eof_len});

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= 8'h00;
      nbits_q <= 4'h0;
      seen_valid_q <= 1'b0;
      invalid_q <= '0;
    end else if (rx_bit.strobe & rx_bit.valid) begin
      // emptied once a byte moves, so a partial byte at eof stays right-aligned
      shift_q <= (nbits_next == `BITS_PER_BYTE) ? 8'h00 : {shift_q[6:0], rx_bit.data};
      nbits_q <= (nbits_next == `BITS_PER_BYTE) ? 4'h0 : nbits_next;
      seen_valid_q <= 1'b1;
      invalid_q <= '0;
    end else if (eof_hit) begin
      shift_q <= 8'h00;
      nbits_q <= 4'h0;
      seen_valid_q <= 1'b0;
      invalid_q <= '0;
    end else if (rx_bit.strobe & seen_valid_q) begin
      invalid_q <= invalid_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // a full byte or an end of frame moves data, even a partial byte
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_q <= '0;
    end else if (rx_bit.strobe & rx_bit.valid & (nbits_next == `BITS_PER_BYTE)) begin
      xfer_q <= '{load: 1'b1, eof: 1'b0, nbits: nbits_next,
                  data: {shift_q[6:0], rx_bit.data}};
    end else if (eof_hit) begin
      xfer_q <= '{load: 1'b1, eof: 1'b1, nbits: nbits_q, data: shift_q};
    end else begin
      xfer_q <= '0;
    end
  end

  assign xfer = xfer_q;

endmodule
`default_nettype wire

// [core/rx_chan_b_irq_enable.sv]
// channel b receive holding register with interrupt enables, apb slave
// How it works
// - enable bit 7 gates the channel b underflow interrupt
// - reading the empty channel b holding register raises underflow
// - enable bit 6 gates the channel b overflow interrupt
// - new data arriving before the old is read raises overflow
// - enable bit 5 gates the channel b end-of-frame interrupt
// - end of frame once invalid bits after valid exceed programmed length
// - length zero ends the frame on the first invalid bit
// - reading the receive status register clears the end-of-frame interrupt
// - enable bit 4 gates the interrupt for data placed in holding register
// - full byte or end of frame, even partial, loads the holding register
`timescale 1ns/1ps
`default_nettype none
`include "rx_b_irq_defines.svh"

module rx_chan_b_irq_enable #(
  parameter int LEN_W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire rx_b_irq_pkg::rx_bit_t RX_BIT,
  output logic IRQ
);
  import rx_b_irq_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic addr_ok;

  logic sel_enable;
  logic sel_hold;
  logic sel_status;
  logic sel_len;
  logic sel_istat;
  logic sel_mask;

  logic [3:0] enable_q;
  logic [3:0] mask_q;
  logic [LEN_W-1:0] eof_len_q;

  rx_xfer_t xfer;
  logic [7:0] hold_data_q;
  logic [3:0] hold_nbits_q;
  logic hold_full_q;
  logic pop_ok_q;
  logic empty_read_q;
  logic pop;
  logic eof_pending_q;

  logic [3:0] event_v;
  logic [3:0] clear_v;
  logic [3:0] istat_q;
  logic irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // apb phases: answer is registered, so every access takes one access cycle

  assign setup = PSEL & ~PENABLE;
  assign done = PSEL & PENABLE & pready_q;
  assign wr_done = done & PWRITE & ~pslverr_q;
  assign rd_done = done & ~PWRITE & ~pslverr_q;

  assign sel_enable = (PADDR == `OFF_IRQ_ENABLE);
  assign sel_hold = (PADDR == `OFF_HOLD_B);
  assign sel_status = (PADDR == `OFF_RX_STATUS);
  assign sel_len = (PADDR == `OFF_EOF_LEN);
  assign sel_istat = (PADDR == `OFF_IRQ_STATUS);
  assign sel_mask = (PADDR == `OFF_IRQ_MASK);
  assign addr_ok = sel_enable | sel_hold | sel_status | sel_len | sel_istat | sel_mask;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  // unmapped offsets answer with an error and have no effect
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~addr_ok;
    end else if (done) begin
      pslverr_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data is captured in the setup cycle and held through the access

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      sel_enable: begin
        rd_mux[`EVENT_HI:`EVENT_LO] = enable_q;
      end
      sel_hold: begin
        if (hold_full_q) begin
          rd_mux[`HOLD_DATA_HI:0] = hold_data_q;
          rd_mux[`HOLD_NBITS_HI:`HOLD_NBITS_LO] = hold_nbits_q;
        end
      end
      sel_status: begin
        rd_mux[`STAT_HOLD_FULL] = hold_full_q;
        rd_mux[`STAT_EOF_PENDING] = eof_pending_q;
        rd_mux[`STAT_NBITS_HI:`STAT_NBITS_LO] = hold_nbits_q;
      end
      sel_len: begin
        rd_mux[LEN_W-1:0] = eof_len_q;
      end
      sel_istat: begin
        rd_mux[`EVENT_HI:`EVENT_LO] = istat_q;
      end
      sel_mask: begin
        rd_mux[`EVENT_HI:`EVENT_LO] = mask_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup & ~PWRITE) begin
      prdata_q <= rd_mux;
    end else if (done) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software control registers

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      enable_q <= `RST_IRQ_ENABLE;
    end else if (wr_done & sel_enable) begin
      enable_q <= PWDATA[`EVENT_HI:`EVENT_LO];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mask_q <= `RST_IRQ_MASK;
    end else if (wr_done & sel_mask) begin
      mask_q <= PWDATA[`EVENT_HI:`EVENT_LO];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      eof_len_q <= `RST_EOF_LEN;
    end else if (wr_done & sel_len) begin
      eof_len_q <= PWDATA[LEN_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit assembly and end-of-frame detection

  rx_b_deframer #(
    .LEN_W(LEN_W)
  ) u_deframer (
    .clk(CLK_SYS),
    .rst(RESET),
    .rx_bit(RX_BIT),
    .eof_len(eof_len_q),
    .xfer(xfer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // holding register; a load landing between setup and access must not be
  // popped by that access, since the master saw the older byte

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pop_ok_q <= 1'b0;
      empty_read_q <= 1'b0;
    end else if (setup) begin
      pop_ok_q <= sel_hold & ~PWRITE & hold_full_q & ~xfer.load;
      empty_read_q <= sel_hold & ~PWRITE & ~hold_full_q;
    end
  end

  assign pop = rd_done & sel_hold & pop_ok_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      hold_data_q <= 8'h00;
      hold_nbits_q <= 4'h0;
    end else if (xfer.load) begin
      hold_data_q <= xfer.data;
      hold_nbits_q <= xfer.nbits;
    end
  end

  // a load wins over a pop in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      hold_full_q <= 1'b0;
    end else if (xfer.load) begin
      hold_full_q <= 1'b1;
    end else if (pop) begin
      hold_full_q <= 1'b0;
    end
  end

  // pending end of frame; an event in the clearing cycle is kept
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      eof_pending_q <= 1'b0;
    end else if (xfer.load & xfer.eof) begin
      eof_pending_q <= 1'b1;
    end else if (rd_done & sel_status) begin
      eof_pending_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // events and sticky status

  always_comb begin
    event_v = 4'h0;
    event_v[`BIT_UNDERFLOW_B-`EVENT_LO] = rd_done & sel_hold & empty_read_q;
    event_v[`BIT_OVERFLOW_B-`EVENT_LO] = xfer.load & hold_full_q & ~pop;
    event_v[`BIT_EOF_B-`EVENT_LO] = xfer.load & xfer.eof;
    event_v[`BIT_FULL_B-`EVENT_LO] = xfer.load;
  end

  // write one clears; a status read also clears the end-of-frame bit
  always_comb begin
    clear_v = 4'h0;
    if (wr_done & sel_istat) begin
      clear_v = PWDATA[`EVENT_HI:`EVENT_LO];
    end
    if (rd_done & sel_status) begin
      clear_v[`BIT_EOF_B-`EVENT_LO] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sticky
      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          istat_q[gi] <= 1'b0;
        end else if (event_v[gi]) begin
          istat_q[gi] <= 1'b1;
        end else if (clear_v[gi]) begin
          istat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request: a condition counts only with its enable and mask set

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & enable_q & mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ = irq_q;

endmodule
`default_nettype wire
